// ==== logic/sseccu_map.svh ====
// Register indices, field positions and reset values of the ECC unit
`ifndef SSECCU_MAP_SVH
`define SSECCU_MAP_SVH

`define SSECCU_IDX_STATUS   4'h0
`define SSECCU_IDX_IRQ_EN   4'h1
`define SSECCU_IDX_IRQ_FLAG 4'h2
`define SSECCU_IDX_PTR_HI   4'h7
`define SSECCU_IDX_PTR_MID  4'h8
`define SSECCU_IDX_PTR_LO   4'h9
`define SSECCU_IDX_DATA_HI  4'hC
`define SSECCU_IDX_DATA_LO  4'hD
`define SSECCU_IDX_CHECK    4'hE
`define SSECCU_IDX_CMD      4'hF

`define SSECCU_BIT_READY     0
`define SSECCU_BIT_SBE       0
`define SSECCU_BIT_CMD_READ  0
`define SSECCU_BIT_CMD_WRITE 1
`define SSECCU_BIT_REPAIR    7

`define SSECCU_RST_IRQ_EN 1'b0
`define SSECCU_PTR_W      24
`define SSECCU_DATA_W     16
`define SSECCU_CHECK_W    6
`define SSECCU_WORD_W     22

`endif

// ==== logic/sseccu_pkg.sv ====
// FSM, request, response and decode types of the ECC unit
`include "sseccu_map.svh"

package sseccu_pkg;

	typedef enum logic {ST_INIT, ST_IDLE} sseccu_fsm_t;

	typedef struct packed {
		logic                          we;
		logic [1:0]                    be;
		logic [`SSECCU_PTR_W-2:0]      addr;
		logic [`SSECCU_DATA_W-1:0]     wdata;
	} sseccu_req_t;

	typedef struct packed {
		logic                          ack;
		logic                          dbl_err;
		logic [`SSECCU_DATA_W-1:0]     rdata;
	} sseccu_rsp_t;

	typedef struct packed {
		logic                          single;
		logic                          dbl;
		logic [`SSECCU_DATA_W-1:0]     data;
	} sseccu_dec_t;

endpackage

// ==== logic/sseccu_top.sv ====
// SECDED ECC unit with memory array, system port and Wishbone registers
// Behaviour
// - Check value covers one aligned 16-bit word
// - Six check bits stored with every word
// - Single flipped bit is corrected on return
// - Two flipped bits flagged, data left uncorrected
// - Ready low blocks access during initialization
// - Interrupt when flag set and enable high
// - Single-bit error sets sticky flag
// - Writing one clears flag, zero ignored
// - Correction applies to reads and write merges
// - Byte writes keep check bits consistent
// - Status readable anytime, writes ignored
// - Debug write stores raw word, clears command
// - Debug read loads raw word, clears command
// - Both commands together: only write performed
// - Repair disable stops read write-back
`timescale 1ns/1ps
`default_nettype none
`include "sseccu_map.svh"

module sseccu_top
	import sseccu_pkg::*;
#(
	parameter int AW = 10
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Wishbone register slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// System memory port
	input  wire logic        sys_req_i,
	input  wire sseccu_req_t sys_cmd_i,
	output sseccu_rsp_t      sys_rsp_o,
	// Interrupt
	output logic             irq_o
);

	localparam logic [23:0] PTR_MASK = 24'(((24'h1 << (AW + 1)) - 24'h1) & 24'hFFFFFE);

	typedef struct packed {
		sseccu_fsm_t                fsm;
		logic [AW-1:0]              init_cnt;
		logic                       ready;
		logic                       irq_en;
		logic                       flag;
		logic                       irq;
		logic [`SSECCU_PTR_W-1:0]   debug_pointer;
		logic [`SSECCU_DATA_W-1:0]  debug_raw_word;
		logic [`SSECCU_CHECK_W-1:0] dchk;
		logic                       repair_dis;
		logic                       cmd_w;
		logic                       cmd_r;
		logic                       wb_ack;
		logic [7:0]                 wb_dat;
		sseccu_rsp_t                rsp;
	} sseccu_state_t;

	sseccu_state_t              s_r;
	sseccu_state_t              s_nxt;
	logic [`SSECCU_WORD_W-1:0]  mem [2**AW];
	logic                       mem_we;
	logic [AW-1:0]              mem_wa;
	logic [`SSECCU_WORD_W-1:0]  mem_wd;
	logic [AW-1:0]              rd_addr;
	logic [`SSECCU_WORD_W-1:0]  word;
	sseccu_dec_t                dec;
	logic                       wb_hit;
	logic                       wb_wr;
	logic [3:0]                 idx;
	logic                       acc;
	logic                       full_wr;
	logic                       sbe_evt;
	logic                       flag_clr;
	logic [15:0]                merged;

	// Hamming position of data bit i, skipping the power-of-two slots
	function automatic logic [4:0] sseccu_dpos(input int i);
		int k;
		logic [4:0] p;
		k = -1;
		p = 5'h00;
		for (int j = 1; j < 22; j++) begin
			if ((j & (j - 1)) != 0) begin
				k++;
				if (k == i)
					p = j[4:0];
			end
		end
		return p;
	endfunction

	function automatic logic [`SSECCU_WORD_W-1:0] sseccu_encode(input logic [15:0] d);
		logic [4:0] c;
		c = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (d[i])
				c = c ^ sseccu_dpos(i);
		end
		return {^{d, c}, c, d};
	endfunction

	// Overall parity odd means one flip, even with a syndrome means two
	function automatic sseccu_dec_t sseccu_decode(input logic [`SSECCU_WORD_W-1:0] w);
		sseccu_dec_t               r;
		logic [4:0]                syn;
		logic                      par;
		logic [`SSECCU_WORD_W-1:0] ref_w;
		ref_w = sseccu_encode(w[15:0]);
		syn = w[20:16] ^ ref_w[20:16];
		par = ^w;
		r.single = par;
		r.dbl = !par && (syn != 5'h00);
		r.data = w[15:0];
		for (int i = 0; i < 16; i++) begin
			if (par && sseccu_dpos(i) == syn)
				r.data[i] = !r.data[i];
		end
		return r;
	endfunction

	assign wb_hit = wb_cyc_i && wb_stb_i && !s_r.wb_ack;
	assign wb_wr = wb_hit && wb_we_i && wb_sel_i[0];
	assign idx = wb_adr_i[5:2];
	// Debug commands win the array over the system port
	assign rd_addr = (s_r.cmd_w || s_r.cmd_r) ? s_r.debug_pointer[AW:1] : sys_cmd_i.addr[AW-1:0];
	assign word = mem[rd_addr];
	assign dec = sseccu_decode(word);
	assign acc = s_r.fsm == ST_IDLE && !s_r.cmd_w && !s_r.cmd_r
		&& sys_req_i && !s_r.rsp.ack;
	assign full_wr = sys_cmd_i.be == 2'b11;
	assign flag_clr = wb_wr && idx == `SSECCU_IDX_IRQ_FLAG && wb_dat_i[`SSECCU_BIT_SBE];

	always_comb begin
		merged = dec.data;
		if (sys_cmd_i.be[0])
			merged[7:0] = sys_cmd_i.wdata[7:0];
		if (sys_cmd_i.be[1])
			merged[15:8] = sys_cmd_i.wdata[15:8];
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.wb_ack = wb_hit;
		s_nxt.rsp.ack = 1'b0;
		mem_we = 1'b0;
		mem_wa = rd_addr;
		mem_wd = word;
		sbe_evt = 1'b0;

		if (wb_hit) begin
			case (idx)
			`SSECCU_IDX_STATUS:   s_nxt.wb_dat = {7'h00, s_r.ready};
			`SSECCU_IDX_IRQ_EN:   s_nxt.wb_dat = {7'h00, s_r.irq_en};
			`SSECCU_IDX_IRQ_FLAG: s_nxt.wb_dat = {7'h00, s_r.flag};
			`SSECCU_IDX_PTR_HI:   s_nxt.wb_dat = s_r.debug_pointer[23:16];
			`SSECCU_IDX_PTR_MID:  s_nxt.wb_dat = s_r.debug_pointer[15:8];
			`SSECCU_IDX_PTR_LO:   s_nxt.wb_dat = s_r.debug_pointer[7:0];
			`SSECCU_IDX_DATA_HI:  s_nxt.wb_dat = s_r.debug_raw_word[15:8];
			`SSECCU_IDX_DATA_LO:  s_nxt.wb_dat = s_r.debug_raw_word[7:0];
			`SSECCU_IDX_CHECK:    s_nxt.wb_dat = {2'h0, s_r.dchk};
			`SSECCU_IDX_CMD:      s_nxt.wb_dat = {s_r.repair_dis, 5'h00, s_r.cmd_w, s_r.cmd_r};
			default:              s_nxt.wb_dat = 8'h00;
			endcase
		end

		if (wb_wr) begin
			case (idx)
			`SSECCU_IDX_IRQ_EN:  s_nxt.irq_en = wb_dat_i[`SSECCU_BIT_SBE];
			// Only address bits inside the array are writable; bit 0 stays zero
			`SSECCU_IDX_PTR_HI:  s_nxt.debug_pointer = {wb_dat_i[7:0], s_r.debug_pointer[15:0]} & PTR_MASK;
			`SSECCU_IDX_PTR_MID: s_nxt.debug_pointer = {s_r.debug_pointer[23:16], wb_dat_i[7:0], s_r.debug_pointer[7:0]} & PTR_MASK;
			`SSECCU_IDX_PTR_LO:  s_nxt.debug_pointer = {s_r.debug_pointer[23:8], wb_dat_i[7:0]} & PTR_MASK;
			`SSECCU_IDX_DATA_HI: s_nxt.debug_raw_word[15:8] = wb_dat_i[7:0];
			`SSECCU_IDX_DATA_LO: s_nxt.debug_raw_word[7:0] = wb_dat_i[7:0];
			`SSECCU_IDX_CHECK:   s_nxt.dchk = wb_dat_i[5:0];
			`SSECCU_IDX_CMD: begin
				s_nxt.repair_dis = wb_dat_i[`SSECCU_BIT_REPAIR];
				// A new command is refused while one is pending
				if (!s_r.cmd_w && !s_r.cmd_r) begin
					if (wb_dat_i[`SSECCU_BIT_CMD_WRITE])
						s_nxt.cmd_w = 1'b1;
					else if (wb_dat_i[`SSECCU_BIT_CMD_READ])
						s_nxt.cmd_r = 1'b1;
				end
			end
			default: ;
			endcase
		end

		case (s_r.fsm)
		ST_INIT: begin
			// All-zero data encodes to all-zero check bits
			mem_we = 1'b1;
			mem_wa = s_r.init_cnt;
			mem_wd = sseccu_encode(16'h0000);
			s_nxt.init_cnt = s_r.init_cnt + 1'b1;
			if (&s_r.init_cnt) begin
				s_nxt.ready = 1'b1;
				s_nxt.fsm = ST_IDLE;
			end
		end
		ST_IDLE: begin
			if (s_r.cmd_w) begin
				mem_we = 1'b1;
				mem_wd = {s_r.dchk, s_r.debug_raw_word};
				s_nxt.cmd_w = 1'b0;
			end else if (s_r.cmd_r) begin
				s_nxt.debug_raw_word = word[15:0];
				s_nxt.dchk = word[21:16];
				s_nxt.cmd_r = 1'b0;
			end else if (acc) begin
				s_nxt.rsp.ack = 1'b1;
				if (sys_cmd_i.we) begin
					// A partial write over a double error is dropped
					s_nxt.rsp.dbl_err = dec.dbl && !full_wr;
					s_nxt.rsp.rdata = 16'h0000;
					sbe_evt = dec.single && !full_wr;
					if (full_wr || !dec.dbl) begin
						mem_we = 1'b1;
						mem_wd = sseccu_encode(merged);
					end
				end else begin
					s_nxt.rsp.dbl_err = dec.dbl;
					s_nxt.rsp.rdata = dec.data;
					sbe_evt = dec.single;
					if (dec.single && !s_r.repair_dis) begin
						mem_we = 1'b1;
						mem_wd = sseccu_encode(dec.data);
					end
				end
			end
		end
		default: s_nxt.fsm = ST_INIT;
		endcase

		// A new error in the clearing cycle keeps the flag set
		s_nxt.flag = (s_r.flag && !flag_clr) || sbe_evt;
		s_nxt.irq = s_nxt.flag && s_nxt.irq_en;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.fsm <= ST_INIT;
			s_r.irq_en <= `SSECCU_RST_IRQ_EN;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Array holds six check bits next to each 16-bit word
	always_ff @(posedge core_clk) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	assign wb_dat_o = {24'h000000, s_r.wb_dat};
	assign wb_ack_o = s_r.wb_ack;
	assign sys_rsp_o = s_r.rsp;
	assign irq_o = s_r.irq;

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	chk_ready_blocks: assert property (!s_r.ready |=> !sys_rsp_o.ack)
		else $error("system access answered before init done");
	chk_irq_gate: assert property (##1 irq_o == $past(s_nxt.flag && s_nxt.irq_en))
		else $error("interrupt output disagrees with flag and enable");
	chk_flag_set: assert property (sbe_evt |=> s_r.flag && (irq_o == s_r.irq_en))
		else $error("single error did not set flag");
	chk_flag_sticky: assert property (s_r.flag && !flag_clr |=> s_r.flag)
		else $error("flag dropped without clear");
	chk_flag_clear: assert property (flag_clr && !sbe_evt |=> !s_r.flag)
		else $error("write one did not clear flag");
	chk_single_fix: assert property (acc && !sys_cmd_i.we && dec.single
		|-> $countones(sseccu_encode(dec.data) ^ word) == 1)
		else $error("single error correction wrong");
	chk_double_report: assert property (acc && !sys_cmd_i.we && dec.dbl
		|=> sys_rsp_o.ack && sys_rsp_o.dbl_err && s_r.flag == $past(s_r.flag && !flag_clr))
		else $error("double error not reported");
	chk_write_consistent: assert property (acc && sys_cmd_i.we && mem_we
		|-> mem_wd == sseccu_encode(mem_wd[15:0]))
		else $error("write stored inconsistent check bits");
	chk_ptr_aligned: assert property (!s_r.debug_pointer[0] && (s_r.debug_pointer & ~PTR_MASK) == 24'h000000)
		else $error("debug pointer not aligned");
	chk_dbg_write: assert property (s_r.fsm == ST_IDLE && s_r.cmd_w
		|-> mem_we && mem_wd == {s_r.dchk, s_r.debug_raw_word} ##1 !s_r.cmd_w)
		else $error("debug write wrong");
	chk_dbg_read: assert property (s_r.fsm == ST_IDLE && s_r.cmd_r && !s_r.cmd_w
		|=> !s_r.cmd_r && {s_r.dchk, s_r.debug_raw_word} == $past(word))
		else $error("debug read wrong");
	chk_dbg_both: assert property (wb_wr && idx == `SSECCU_IDX_CMD && wb_dat_i[1:0] == 2'b11
		&& !s_r.cmd_w && !s_r.cmd_r |=> s_r.cmd_w && !s_r.cmd_r)
		else $error("combined command not reduced to write");
	chk_no_repair: assert property (acc && !sys_cmd_i.we && s_r.repair_dis |-> !mem_we)
		else $error("repair happened while disabled");
	chk_status_ro: assert property (s_r.ready |=> s_r.ready)
		else $error("ready status changed after init");
	chk_sys_ack_pulse: assert property (sys_rsp_o.ack
		|=> !sys_rsp_o.ack)
		else $error("system ack longer than one cycle");
	chk_wb_ack_pulse: assert property (wb_ack_o
		|=> !wb_ack_o)
		else $error("register ack longer than one cycle");
	chk_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o)
		else $error("register request not answered");
	chk_status_read: assert property (wb_hit && idx == `SSECCU_IDX_STATUS
		|=> wb_dat_o[7:0] == {7'h00, $past(s_r.ready)})
		else $error("status read wrong");
	chk_ready_init: assert property (s_r.fsm == ST_INIT
		|-> !s_r.ready)
		else $error("ready shown during init");
	chk_ready_idle: assert property (s_r.fsm == ST_IDLE
		|-> s_r.ready)
		else $error("ready missing after init");
	chk_init_zero: assert property (s_r.fsm == ST_INIT
		|-> mem_we && mem_wd == 22'h000000)
		else $error("init did not write zero words");
	chk_irq_level: assert property (1'b1
		|-> irq_o == (s_r.flag && s_r.irq_en))
		else $error("interrupt level wrong");
	chk_en_write: assert property (wb_wr && idx == `SSECCU_IDX_IRQ_EN
		|=> s_r.irq_en == $past(wb_dat_i[0]))
		else $error("interrupt enable write lost");
	chk_flag_quiet: assert property (!s_r.flag && !sbe_evt
		|=> !s_r.flag)
		else $error("flag set without error");
	chk_flag_zero_write: assert property (wb_wr && idx == `SSECCU_IDX_IRQ_FLAG && !wb_dat_i[0]
		&& s_r.flag |=> s_r.flag)
		else $error("writing zero cleared flag");
	chk_double_data: assert property (acc && !sys_cmd_i.we && dec.dbl
		|=> sys_rsp_o.rdata == $past(word[15:0]))
		else $error("double error data altered");
	chk_double_no_write: assert property (acc && !sys_cmd_i.we && dec.dbl
		|-> !mem_we)
		else $error("double error data written back");
	chk_read_clean: assert property (acc && !sys_cmd_i.we && !dec.single && !dec.dbl
		|=> sys_rsp_o.rdata == $past(word[15:0]) && !sys_rsp_o.dbl_err)
		else $error("clean read altered");
	chk_repair_write: assert property (acc && !sys_cmd_i.we && dec.single && !s_r.repair_dis
		|-> mem_we && mem_wd == sseccu_encode(dec.data))
		else $error("single error not repaired");
	chk_single_event: assert property (acc && dec.single && !(sys_cmd_i.we && full_wr)
		|-> sbe_evt)
		else $error("single error not reported");
	chk_full_write: assert property (acc && sys_cmd_i.we && full_wr
		|-> !sbe_evt && mem_we)
		else $error("full word write wrong");
	chk_byte_keep: assert property (acc && sys_cmd_i.we && sys_cmd_i.be == 2'b01 && !dec.dbl
		|-> mem_wd[15:8] == dec.data[15:8])
		else $error("byte write lost other byte");
	chk_sys_addr: assert property (acc
		|-> mem_wa == sys_cmd_i.addr[AW-1:0])
		else $error("system access to wrong word");
	chk_dbg_addr: assert property (s_r.fsm == ST_IDLE && s_r.cmd_w
		|-> mem_wa == s_r.debug_pointer[AW:1])
		else $error("debug write to wrong word");
	chk_cmd_single: assert property (1'b1
		|-> !(s_r.cmd_w && s_r.cmd_r))
		else $error("both debug commands pending");

	cov_init_done: cover property (!s_r.ready ##1 s_r.ready);
	cov_single_read: cover property (acc && !sys_cmd_i.we && dec.single);
	cov_partial_write: cover property (acc && sys_cmd_i.we && !full_wr);
	cov_dbg_write_read: cover property (s_r.cmd_w ##[1:20] s_r.cmd_r);
	cov_double_read: cover property (acc && !sys_cmd_i.we && dec.dbl);

endmodule

`default_nettype wire

// ==== verification/sseccu_sys_host.sv ====
// Requester model on the system memory port of the ECC unit
`timescale 1ns/1ps
`default_nettype none

module sseccu_sys_host
	import sseccu_pkg::*;
(
	// Clock
	input  wire logic        core_clk,
	// Memory port
	output logic             req,
	output sseccu_req_t      cmd,
	input  wire sseccu_rsp_t rsp
);
	int n_wait;

	initial begin
		req = 1'b0;
		cmd = '0;
	end

	// Random idle gap varies spacing; one edge at least keeps one assignment per step
	task automatic acc(input logic we, input logic [1:0] be, input logic [3:0] a,
		input logic [15:0] d, output bit tmo);
		repeat (1 + $urandom_range(1)) @(posedge core_clk);
		req <= 1'b1;
		cmd <= '{we: we, be: be, addr: 23'(a), wdata: d};
		n_wait = 0;
		do begin
			@(posedge core_clk);
			n_wait++;
		end while (!rsp.ack && n_wait < 200);
		tmo = !rsp.ack;
		req <= 1'b0;
		// Released lines must not keep showing the old request
		cmd <= ~cmd;
	endtask
endmodule

`default_nettype wire

// ==== verification/sseccu_top_tb.sv ====
// Self-checking bench of the ECC unit
`timescale 1ns/1ps
`default_nettype none
`include "sseccu_map.svh"

module sseccu_top_tb
	import sseccu_pkg::*;
;
	typedef struct {
		string       nm;
		logic [16:0] v;
	} sseccu_exp_t;

	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        wb_cs = 1'b0;
	logic        wb_we = 1'b0;
	logic [5:0]  wb_adr = 6'h00;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack;
	logic        req;
	sseccu_req_t cmd;
	sseccu_rsp_t rsp;
	logic        irq;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	int          cyc_n = 0;
	sseccu_exp_t expq[$];
	sseccu_exp_t ex;

	sseccu_top #(.AW(4)) DUT (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cs),
		.wb_stb_i(wb_cs), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .sys_req_i(req),
		.sys_cmd_i(cmd), .sys_rsp_o(rsp), .irq_o(irq));
	sseccu_sys_host host (.core_clk(core_clk), .req(req), .cmd(cmd), .rsp(rsp));

	always #10 core_clk = ~core_clk;

	task automatic tally_and_finish();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [16:0] e, input logic [16:0] s);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	always @(posedge core_clk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// Results are matched in order against the oldest note
	always @(posedge core_clk) begin
		if ((wb_ack && !wb_we) || (rsp.ack && !cmd.we)) begin
			if (expq.size() == 0)
				cmp("queue", 17'h0, 17'h1FFFF);
			else begin
				ex = expq.pop_front();
				if (ex.nm != "")
					cmp(ex.nm, ex.v, wb_ack ? wb_dat_o[16:0] : {rsp.dbl_err, rsp.rdata});
			end
		end
	end

	// A read passes its expected byte
	task automatic wb(input logic we, input logic [3:0] idx, input logic [7:0] d,
		input string nm = "", input logic s0 = 1'b1);
		int n;
		if (!we)
			expq.push_back('{nm, {9'h0, d}});
		wb_cs <= 1'b1;
		wb_we <= we;
		wb_adr <= {idx, 2'($urandom)};
		wb_sel <= {3'($urandom), s0};
		wb_dat <= {24'($urandom), d};
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (!wb_ack && n < 50);
		if (!wb_ack)
			cmp("wb_ack", 17'h1, 17'h0);
		wb_cs <= 1'b0;
		@(posedge core_clk);
	endtask

	// Write data, or expected read result with double flag on top
	task automatic sys(input logic we, input logic [1:0] be, input logic [3:0] a,
		input logic [16:0] v);
		bit t;
		if (!we)
			expq.push_back('{"sys_rdata", v});
		host.acc(we, be, a, v[15:0], t);
		if (t)
			cmp("sys_ack", 17'h1, 17'h0);
	endtask

	task automatic dbg(input logic [3:0] a, input logic [15:0] d, input logic [7:0] op);
		wb(1, `SSECCU_IDX_PTR_LO, {3'h0, a, 1'b1});
		wb(1, `SSECCU_IDX_DATA_HI, d[15:8]);
		wb(1, `SSECCU_IDX_DATA_LO, d[7:0]);
		wb(1, `SSECCU_IDX_CHECK, 8'h00);
		wb(1, `SSECCU_IDX_CMD, op);
		repeat (2) @(posedge core_clk);
		wb(0, `SSECCU_IDX_CMD, op & 8'h80, "cmd_clear");
	endtask

	task automatic irq_is(input logic e);
		repeat (2) @(posedge core_clk);
		cmp("irq_o", {16'h0, e}, {16'h0, irq});
	endtask

	initial begin
		logic [3:0]  a;
		logic [3:0]  k;
		logic [15:0] d;
		logic [7:0]  b;
		logic [7:0]  rep;
		void'($urandom(70));
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		wb(0, `SSECCU_IDX_STATUS, 8'h00, "ready_early");
		wb(0, `SSECCU_IDX_IRQ_EN, 8'h00, "irq_en_rst");
		repeat (20) @(posedge core_clk);
		wb(1, `SSECCU_IDX_STATUS, 8'hFE);
		wb(0, `SSECCU_IDX_STATUS, 8'h01, "status");
		wb(1, 4'h3, 8'hFF);
		wb(0, 4'h3, 8'h00, "reserved");
		wb(1, `SSECCU_IDX_PTR_LO, 8'hFF);
		wb(0, `SSECCU_IDX_PTR_LO, 8'h1E, "ptr_lo");
		for (a = 4'h0; a < 4'h8; a++) begin
			d = 16'($urandom);
			b = 8'($urandom);
			sys(1, 2'b11, a, {1'b0, d});
			sys(1, a[0] ? 2'b10 : 2'b01, a, {1'b0, b, b});
			sys(0, 2'b11, a, {1'b0, a[0] ? {b, d[7:0]} : {d[15:8], b}});
		end
		// Zero data carries zero check bits, so a raw word of one set bit is a single flip
		for (a = 4'h8; a < 4'hE; a++) begin
			k = 4'($urandom);
			rep = a[0] ? 8'h80 : 8'h00;
			dbg(a, 16'h1 << k, 8'h02 | rep);
			if (a < 4'hC) begin
				sys(0, 2'b11, a, 17'h0);
				dbg(a, 16'h0, 8'h01 | rep);
				d = rep[7] ? 16'h1 << k : 16'h0;
				wb(0, `SSECCU_IDX_DATA_HI, d[15:8], "raw_hi");
				wb(0, `SSECCU_IDX_DATA_LO, d[7:0], "raw_lo");
				wb(0, `SSECCU_IDX_CHECK, 8'h00, "raw_check");
			end else begin
				sys(1, 2'b01, a, {9'h0, b});
				sys(0, 2'b11, a, {9'h0, b});
			end
		end
		wb(0, `SSECCU_IDX_IRQ_FLAG, 8'h01, "flag_set");
		irq_is(1'b0);
		wb(1, `SSECCU_IDX_IRQ_EN, 8'h01, "", 1'b0);
		irq_is(1'b0);
		wb(1, `SSECCU_IDX_IRQ_EN, 8'h01);
		irq_is(1'b1);
		wb(1, `SSECCU_IDX_IRQ_FLAG, 8'h00);
		wb(0, `SSECCU_IDX_IRQ_FLAG, 8'h01, "flag_keep");
		wb(1, `SSECCU_IDX_IRQ_FLAG, 8'h01);
		wb(0, `SSECCU_IDX_IRQ_FLAG, 8'h00, "flag_clr");
		irq_is(1'b0);
		k = 4'($urandom_range(14));
		dbg(4'hE, 16'h3 << k, 8'h02);
		sys(0, 2'b11, 4'hE, {1'b1, 16'h3 << k});
		wb(0, `SSECCU_IDX_IRQ_FLAG, 8'h00, "flag_dbl");
		sys(1, 2'b11, 4'hF, {1'b0, 16'($urandom) | 16'h1});
		dbg(4'hF, 16'h0, 8'h03);
		sys(0, 2'b11, 4'hF, 17'h0);
		tally_and_finish();
	end
endmodule

`default_nettype wire
